// ===== sfp_top.sv
// Purpose: security fault flags and eight-region protection check
// Assumes: core event and access inputs are on i_clk, no synchronisers
// Notes: check result is registered, one cycle after the access
//
// What this block does
// - fault_address_valid at bit 6 set on valid capture; bus fault may clear.
// - lazy_preserve_error bit 5 set on attribution violation during lazy preserve.
// - invalid_transition bit 4 set on unmarked secure-to-nonsecure branch; raise exception.
// - attribution_violation bit 3 set when nonsecure request hits secure address.
// - attribution_violation not set during lazy preservation or vector fetch.
// - invalid_exception_return bit 2 on nonsecure return with stacking 0 or secure 1.
// - invalid_integrity_signature bit 1 set on bad stack frame signature.
// - invalid_entry_point bit 0 set when nonsecure call targets non-gateway instruction.
// - invalid_entry_point also set for gateway without nonsecure callable region.
// - fault address register holds violating access address while valid flag set.
// - fault registers read zero, ignore writes from nonsecure; not banked.
// - eight regions with own location, size, permissions, attributes; attributes exported.
// - access outside system space hitting two or more enabled regions faults.
// - fetches and data accesses use one unified region map.
// - prohibited access raises memory management exception.
// - type, control and region registers banked between security states.
// - info register bits 15:8 report region count, 00 absent, 08 present.
// - info register bit 0 reads 0, unified regions.
// - control register enables unit, selects background map and handler checking.
// - privileged miss outside system space uses background map when enabled, otherwise faults.
// - checking bypassed at priorities -1..-3 unless handler check enabled.
// - alias n replaces region select bits 1:0 with n, then accesses region.
`timescale 1ns/10ps
module sfp_top import sfp_pkg::*; #(
  parameter bit MPU_PRESENT = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [31:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic i_avs_nonsecure,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_attr_viol,
  input wire logic [31:0] i_attr_addr,
  input wire logic i_attr_lazy,
  input wire logic i_attr_vector,
  input wire logic i_bad_transition,
  input wire logic i_exc_ret,
  input wire logic i_exc_ret_nonsecure,
  input wire logic i_exc_ret_stacking,
  input wire logic i_exc_ret_secure,
  input wire logic i_unstack_bad_sig,
  input wire logic i_ns_entry,
  input wire logic i_entry_is_gateway,
  input wire logic i_entry_callable,
  input wire logic i_other_fault,
  input wire logic i_acc_valid,
  input wire logic [31:0] i_acc_addr,
  input wire logic i_acc_write,
  input wire logic i_acc_fetch,
  input wire logic i_acc_priv,
  input wire logic i_acc_nonsecure,
  input wire logic i_acc_neg_prio,
  output logic [SF_WIDTH-1:0] o_sf_flags,
  output logic o_sec_fault_exc,
  output logic o_chk_valid,
  output logic o_chk_fault,
  output logic o_chk_overlap,
  output logic [7:0] o_chk_attr,
  output logic o_mem_mgmt_exc
);

  function automatic sfp_slot_e decode_slot(input logic [31:0] a);
    case (a)
      ADDR_INFO: decode_slot = SFP_SL_INFO;
      ADDR_CTRL: decode_slot = SFP_SL_CTRL;
      ADDR_RSEL: decode_slot = SFP_SL_RSEL;
      ADDR_RBASE, ADDR_RBASE_A1, ADDR_RBASE_A2, ADDR_RBASE_A3: decode_slot = SFP_SL_RBASE;
      ADDR_RLIM, ADDR_RLIM_A1, ADDR_RLIM_A2, ADDR_RLIM_A3: decode_slot = SFP_SL_RLIM;
      ADDR_ATTR_LO: decode_slot = SFP_SL_ATTR_LO;
      ADDR_ATTR_HI: decode_slot = SFP_SL_ATTR_HI;
      ADDR_SF_STATUS: decode_slot = SFP_SL_SFS;
      ADDR_SF_ADDRESS: decode_slot = SFP_SL_SFA;
      default: decode_slot = SFP_SL_NONE;
    endcase
  endfunction : decode_slot

  // alias number 1..3, zero for the plain base and limit addresses
  function automatic logic [1:0] alias_num(input logic [31:0] a);
    case (a)
      ADDR_RBASE_A1, ADDR_RLIM_A1: alias_num = 2'h1;
      ADDR_RBASE_A2, ADDR_RLIM_A2: alias_num = 2'h2;
      ADDR_RBASE_A3, ADDR_RLIM_A3: alias_num = 2'h3;
      default: alias_num = 2'h0;
    endcase
  endfunction : alias_num

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int k = 0; k < 4; k++) begin
      merge_be[8*k +: 8] = be[k] ? wd[8*k +: 8] : old[8*k +: 8];
    end
  endfunction : merge_be

  // banked configuration, index 1 is the non-secure copy
  logic [2:0] ctrl [2];
  logic [7:0] rsel [2];
  logic [31:0] rbase [2][NUM_REGIONS];
  logic [31:0] rlim [2][NUM_REGIONS];
  logic [31:0] attr_tab [2][2];
  logic [2:0] next_ctrl [2];
  logic [7:0] next_rsel [2];
  logic [31:0] next_rbase [2][NUM_REGIONS];
  logic [31:0] next_rlim [2][NUM_REGIONS];
  logic [31:0] next_attr_tab [2][2];
  logic [SF_WIDTH-1:0] sf_status;
  logic [SF_WIDTH-1:0] next_sf_status;
  logic [31:0] sf_addr;
  logic [31:0] next_sf_addr;
  logic next_sec_fault_exc;
  sfp_bus_e bus_state;
  sfp_bus_e next_bus_state;
  logic [31:0] next_readdata;
  logic next_waitrequest;

  sfp_slot_e slot;
  logic [1:0] anum;
  logic bank;
  logic [REG_IDX_W-1:0] ridx;
  logic [7:0] rsel_eff;
  logic wr_go;
  logic [SF_WIDTH-1:0] sf_set;
  logic [SF_WIDTH-1:0] sf_clr;
  logic [31:0] info_word;

  assign info_word = {16'h0000, (MPU_PRESENT ? INFO_COUNT_PRESENT : INFO_COUNT_ABSENT),
                      7'h00, INFO_UNIFIED};

  // register access: one wait cycle, then a single cycle with waitrequest low
  always_comb begin
    slot = decode_slot(i_avs_address);
    anum = alias_num(i_avs_address);
    bank = i_avs_nonsecure;
    rsel_eff = (anum != 2'h0) ? {rsel[bank][7:2], anum} : rsel[bank];
    ridx = rsel_eff[REG_IDX_W-1:0];
    wr_go = (bus_state == SFP_BUS_ACK) && i_avs_write;
    next_bus_state = SFP_BUS_IDLE;
    next_waitrequest = 1'b1;
    next_readdata = o_avs_readdata;
    if ((bus_state == SFP_BUS_IDLE) && (i_avs_read || i_avs_write)) begin
      next_bus_state = SFP_BUS_ACK;
      next_waitrequest = 1'b0;
      next_readdata = 32'h0000_0000;
      if (i_avs_read) begin
        case (slot)
          SFP_SL_INFO: next_readdata = info_word;
          SFP_SL_CTRL: next_readdata = {29'h0, ctrl[bank]};
          SFP_SL_RSEL: next_readdata = {24'h000000, rsel[bank]};
          SFP_SL_RBASE: next_readdata = rbase[bank][ridx];
          SFP_SL_RLIM: next_readdata = rlim[bank][ridx];
          SFP_SL_ATTR_LO: next_readdata = attr_tab[bank][0];
          SFP_SL_ATTR_HI: next_readdata = attr_tab[bank][1];
          SFP_SL_SFS: next_readdata = bank ? 32'h0 : {25'h0, sf_status};
          SFP_SL_SFA: next_readdata = bank ? 32'h0 : sf_addr;
          default: next_readdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_state <= SFP_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      bus_state <= next_bus_state;
      o_avs_waitrequest <= next_waitrequest;
      o_avs_readdata <= next_readdata;
    end
  end

  // configuration writes take effect at the edge where waitrequest is seen low
  always_comb begin
    next_ctrl = ctrl;
    next_rsel = rsel;
    next_rbase = rbase;
    next_rlim = rlim;
    next_attr_tab = attr_tab;
    if ((bus_state == SFP_BUS_ACK) && (i_avs_read || i_avs_write) && (anum != 2'h0)) begin
      next_rsel[bank] = rsel_eff;
    end
    if (wr_go && MPU_PRESENT) begin
      case (slot)
        SFP_SL_CTRL: next_ctrl[bank] = 3'(merge_be({29'h0, ctrl[bank]}, i_avs_writedata,
                                                   i_avs_byteenable));
        SFP_SL_RSEL: next_rsel[bank] = 8'(merge_be({24'h0, rsel[bank]}, i_avs_writedata,
                                                   i_avs_byteenable));
        SFP_SL_RBASE: next_rbase[bank][ridx] = merge_be(rbase[bank][ridx], i_avs_writedata,
                                                        i_avs_byteenable);
        SFP_SL_RLIM: next_rlim[bank][ridx] = merge_be(rlim[bank][ridx], i_avs_writedata,
                                                      i_avs_byteenable);
        SFP_SL_ATTR_LO: next_attr_tab[bank][0] = merge_be(attr_tab[bank][0], i_avs_writedata,
                                                          i_avs_byteenable);
        SFP_SL_ATTR_HI: next_attr_tab[bank][1] = merge_be(attr_tab[bank][1], i_avs_writedata,
                                                          i_avs_byteenable);
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // regions reset disabled so a fresh unit checks nothing stale
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int b = 0; b < 2; b++) begin
        ctrl[b] <= CTRL_RESET;
        rsel[b] <= 8'h00;
        attr_tab[b][0] <= 32'h0000_0000;
        attr_tab[b][1] <= 32'h0000_0000;
        for (int r = 0; r < NUM_REGIONS; r++) begin
          rbase[b][r] <= 32'h0000_0000;
          rlim[b][r] <= 32'h0000_0000;
        end
      end
    end else begin
      ctrl <= next_ctrl;
      rsel <= next_rsel;
      rbase <= next_rbase;
      rlim <= next_rlim;
      attr_tab <= next_attr_tab;
    end
  end

  // security fault flags: hardware set wins over a same-cycle software clear
  always_comb begin
    sf_set = '0;
    sf_set[SF_ADDR_VALID] = i_attr_viol;
    sf_set[SF_LAZY] = i_attr_viol && i_attr_lazy;
    sf_set[SF_TRANSITION] = i_bad_transition;
    sf_set[SF_ATTRIB] = i_attr_viol && !i_attr_lazy && !i_attr_vector;
    sf_set[SF_EXCEPTION_RETURN_CODE] = i_exc_ret && i_exc_ret_nonsecure &&
                            (!i_exc_ret_stacking || i_exc_ret_secure);
    sf_set[SF_SIGNATURE] = i_unstack_bad_sig;
    sf_set[SF_ENTRY] = i_ns_entry && (!i_entry_is_gateway || !i_entry_callable);
    sf_clr = '0;
    if (wr_go && !bank && (slot == SFP_SL_SFS)) begin
      sf_clr = SF_WIDTH'(merge_be(32'h0, i_avs_writedata, i_avs_byteenable));
    end
    sf_clr[SF_ADDR_VALID] = sf_clr[SF_ADDR_VALID] || i_other_fault;
    next_sf_status = (sf_status & ~sf_clr) | sf_set;
    next_sf_addr = sf_addr;
    if (wr_go && !bank && (slot == SFP_SL_SFA)) begin
      next_sf_addr = merge_be(sf_addr, i_avs_writedata, i_avs_byteenable);
    end
    if (i_attr_viol) begin
      next_sf_addr = i_attr_addr;
    end
    next_sec_fault_exc = |sf_set[SF_LAZY:SF_ENTRY];
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sf_status <= SF_RESET;
      sf_addr <= 32'h0000_0000;
      o_sf_flags <= SF_RESET;
      o_sec_fault_exc <= 1'b0;
    end else begin
      sf_status <= next_sf_status;
      sf_addr <= next_sf_addr;
      o_sf_flags <= next_sf_status;
      o_sec_fault_exc <= next_sec_fault_exc;
    end
  end

  // access check: decided in the access cycle, result flopped for the core
  logic [NUM_REGIONS-1:0] hit;
  logic [3:0] hit_cnt;
  logic [REG_IDX_W-1:0] hit_idx;
  logic abank;
  logic active;
  logic sys_space;
  logic deny;
  logic overlap;
  logic [2:0] attr_sel;
  logic [31:0] attr_word;
  logic [7:0] next_attr;
  logic next_chk_valid;
  logic next_chk_fault;

  always_comb begin
    abank = i_acc_nonsecure;
    active = MPU_PRESENT && ctrl[abank][CTRL_ENABLE] &&
             !(i_acc_neg_prio && !ctrl[abank][CTRL_HANDLER_CHECK]);
    sys_space = (i_acc_addr[31:20] == SYS_SPACE_TOP);
    hit_cnt = 4'h0;
    hit_idx = '0;
    for (int r = 0; r < NUM_REGIONS; r++) begin
      hit[r] = rlim[abank][r][RLIM_ENABLE] &&
               (i_acc_addr[31:REGION_LSB] >= rbase[abank][r][31:REGION_LSB]) &&
               (i_acc_addr[31:REGION_LSB] <= rlim[abank][r][31:REGION_LSB]);
      hit_cnt = hit_cnt + {3'h0, hit[r]};
      if (hit[r]) begin
        hit_idx = REG_IDX_W'(r);
      end
    end
    overlap = (hit_cnt > 4'h1);
    attr_sel = rlim[abank][hit_idx][RLIM_ATTR_LSB +: 3];
    attr_word = attr_tab[abank][attr_sel[2]];
    next_attr = attr_word[8*attr_sel[1:0] +: 8];
    if (!active || sys_space) begin
      deny = 1'b0;
    end else if (overlap) begin
      deny = 1'b1;
    end else if (hit_cnt == 4'h1) begin
      deny = (!i_acc_priv && !rbase[abank][hit_idx][RBASE_AP_ANY]) ||
             (i_acc_write && rbase[abank][hit_idx][RBASE_AP_RO]) ||
             (i_acc_fetch && rbase[abank][hit_idx][RBASE_XN]);
    end else begin
      deny = !(i_acc_priv && ctrl[abank][CTRL_BACKGROUND]);
    end
    next_chk_valid = i_acc_valid;
    next_chk_fault = i_acc_valid && deny;
    if (hit_cnt == 4'h0) begin
      next_attr = 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_chk_valid <= 1'b0;
      o_chk_fault <= 1'b0;
      o_chk_overlap <= 1'b0;
      o_chk_attr <= 8'h00;
      o_mem_mgmt_exc <= 1'b0;
    end else begin
      o_chk_valid <= next_chk_valid;
      o_chk_fault <= next_chk_fault;
      o_chk_overlap <= i_acc_valid && active && !sys_space && overlap;
      o_chk_attr <= next_attr;
      o_mem_mgmt_exc <= next_chk_fault;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_addr_valid;
    i_attr_viol |=> o_sf_flags[SF_ADDR_VALID] && (sf_addr == $past(i_attr_addr));
  endproperty
  a_addr_valid: assert property (p_addr_valid) else $error("address not captured");
  property p_lazy;
    i_attr_viol && i_attr_lazy |=> o_sf_flags[SF_LAZY] && !$rose(o_sf_flags[SF_ATTRIB]);
  endproperty
  a_lazy: assert property (p_lazy) else $error("lazy error flag wrong");
  property p_transition;
    i_bad_transition |=> o_sf_flags[SF_TRANSITION] && o_sec_fault_exc;
  endproperty
  a_transition: assert property (p_transition) else $error("transition not raised");
  property p_attrib_cause;
    $rose(o_sf_flags[SF_ATTRIB]) |-> $past(i_attr_viol && !i_attr_lazy && !i_attr_vector);
  endproperty
  a_attrib_cause: assert property (p_attrib_cause) else $error("attribution flag uncaused");
  property p_exception_return_code;
    i_exc_ret && i_exc_ret_nonsecure && !i_exc_ret_stacking |=> o_sf_flags[SF_EXCEPTION_RETURN_CODE];
  endproperty
  a_exception_return_code: assert property (p_exception_return_code) else $error("bad return not flagged");
  property p_entry;
    i_ns_entry && i_entry_is_gateway && !i_entry_callable |=> o_sf_flags[SF_ENTRY];
  endproperty
  a_entry: assert property (p_entry) else $error("entry point not flagged");
  property p_sticky;
    o_sf_flags[SF_TRANSITION] && !sf_clr[SF_TRANSITION] |=> o_sf_flags[SF_TRANSITION];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag dropped");
  property p_ns_raz;
    !o_avs_waitrequest && $past(i_avs_read && i_avs_nonsecure &&
      (i_avs_address == ADDR_SF_STATUS || i_avs_address == ADDR_SF_ADDRESS))
      |-> o_avs_readdata == 32'h0;
  endproperty
  a_ns_raz: assert property (p_ns_raz) else $error("nonsecure read not zero");
  property p_overlap;
    i_acc_valid && active && !sys_space && (hit_cnt > 4'h1) |=> o_chk_fault && o_mem_mgmt_exc;
  endproperty
  a_overlap: assert property (p_overlap) else $error("overlap did not fault");
  property p_handler_bypass;
    i_acc_valid && i_acc_neg_prio && !ctrl[i_acc_nonsecure][CTRL_HANDLER_CHECK]
      |=> o_chk_valid && !o_chk_fault;
  endproperty
  a_handler_bypass: assert property (p_handler_bypass) else $error("handler not bypassed");
  property p_background;
    i_acc_valid && active && !sys_space && (hit_cnt == 4'h0) && i_acc_priv
      |=> o_chk_fault == !$past(ctrl[abank][CTRL_BACKGROUND]);
  endproperty
  a_background: assert property (p_background) else $error("background map wrong");
  property p_info;
    !o_avs_waitrequest && $past(i_avs_read && i_avs_address == ADDR_INFO)
      |-> o_avs_readdata[15:8] == INFO_COUNT_PRESENT && !o_avs_readdata[0];
  endproperty
  a_info: assert property (p_info) else $error("info register wrong");
  c_overlap: cover property (o_chk_overlap && o_chk_fault);
  c_clear: cover property (o_sf_flags[SF_ATTRIB] ##1 !o_sf_flags[SF_ATTRIB]);
  c_alias: cover property (wr_go && anum == 2'h3);
endmodule : sfp_top

// ===== sfp_pkg.sv
// Purpose: constants for the security fault and region protection block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, word access only
// Notes: two banks, index 0 secure, index 1 non-secure
package sfp_pkg;
  localparam int NUM_REGIONS = 8;
  localparam int REG_IDX_W = 3;
  // register byte addresses
  localparam logic [31:0] ADDR_INFO = 32'he000ed90;
  localparam logic [31:0] ADDR_CTRL = 32'he000ed94;
  localparam logic [31:0] ADDR_RSEL = 32'he000ed98;
  localparam logic [31:0] ADDR_RBASE = 32'he000ed9c;
  localparam logic [31:0] ADDR_RLIM = 32'he000eda0;
  localparam logic [31:0] ADDR_RBASE_A1 = 32'he000eda4;
  localparam logic [31:0] ADDR_RLIM_A1 = 32'he000eda8;
  localparam logic [31:0] ADDR_RBASE_A2 = 32'he000edac;
  localparam logic [31:0] ADDR_RLIM_A2 = 32'he000edb0;
  localparam logic [31:0] ADDR_RBASE_A3 = 32'he000edb4;
  localparam logic [31:0] ADDR_RLIM_A3 = 32'he000edb8;
  localparam logic [31:0] ADDR_ATTR_LO = 32'he000edc0;
  localparam logic [31:0] ADDR_ATTR_HI = 32'he000edc4;
  localparam logic [31:0] ADDR_SF_STATUS = 32'he000ede4;
  localparam logic [31:0] ADDR_SF_ADDRESS = 32'he000ede8;
  // control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_HANDLER_CHECK = 1;
  localparam int CTRL_BACKGROUND = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // info fields
  localparam int INFO_COUNT_LSB = 8;
  localparam logic [7:0] INFO_COUNT_ABSENT = 8'h00;
  localparam logic [7:0] INFO_COUNT_PRESENT = 8'h08;
  localparam logic INFO_UNIFIED = 1'b0;
  // region fields
  localparam int RBASE_XN = 0;
  localparam int RBASE_AP_ANY = 1;
  localparam int RBASE_AP_RO = 2;
  localparam int RLIM_ENABLE = 0;
  localparam int RLIM_ATTR_LSB = 1;
  localparam int REGION_LSB = 5;
  localparam logic [11:0] SYS_SPACE_TOP = 12'he00;
  // security fault status fields
  localparam int SF_ENTRY = 0;
  localparam int SF_SIGNATURE = 1;
  localparam int SF_EXCEPTION_RETURN_CODE = 2;
  localparam int SF_ATTRIB = 3;
  localparam int SF_TRANSITION = 4;
  localparam int SF_LAZY = 5;
  localparam int SF_ADDR_VALID = 6;
  localparam int SF_WIDTH = 7;
  localparam logic [6:0] SF_RESET = 7'h00;
  typedef enum logic [3:0] {
    SFP_SL_NONE = 4'b0000, SFP_SL_INFO = 4'b0001, SFP_SL_CTRL = 4'b0010,
    SFP_SL_RSEL = 4'b0011, SFP_SL_RBASE = 4'b0100, SFP_SL_RLIM = 4'b0101,
    SFP_SL_ATTR_LO = 4'b0110, SFP_SL_ATTR_HI = 4'b0111, SFP_SL_SFS = 4'b1000,
    SFP_SL_SFA = 4'b1001
  } sfp_slot_e;
  typedef enum logic {SFP_BUS_IDLE = 1'b0, SFP_BUS_ACK = 1'b1} sfp_bus_e;
endpackage : sfp_pkg

// ===== sfp_core_model.sv
// Purpose: core-side model that raises fault events and access checks
// Assumes: one request at a time, launched just after a rising edge
// Notes: released address lines show the inverse of the last value
`timescale 1ns/10ps
module sfp_core_model (
  input wire logic i_clk,
  output logic [12:0] o_ev,
  output logic [31:0] o_attr_addr,
  output logic o_acc_valid,
  output logic [31:0] o_acc_addr,
  output logic [4:0] o_acc_kind
);
  initial begin
    o_ev = 13'h0000;
    o_attr_addr = 32'h00000000;
    o_acc_valid = 1'b0;
    o_acc_addr = 32'h00000000;
    o_acc_kind = 5'h00;
  end

  // event pulses last exactly one cycle, as the core would issue them
  task automatic pulse(input logic [12:0] v, input logic [31:0] a);
    @(posedge i_clk);
    o_ev <= v;
    o_attr_addr <= a;
    @(posedge i_clk);
    o_ev <= 13'h0000;
    o_attr_addr <= ~a;
  endtask : pulse

  // kind is {write, fetch, priv, nonsecure, neg_prio}
  task automatic access(input logic [31:0] a, input logic [4:0] k);
    @(posedge i_clk);
    o_acc_valid <= 1'b1;
    o_acc_addr <= a;
    o_acc_kind <= k;
    @(posedge i_clk);
    o_acc_valid <= 1'b0;
    o_acc_addr <= ~a;
    o_acc_kind <= ~k;
  endtask : access
endmodule : sfp_core_model

// ===== sfp_top_bench.sv
// Purpose: self-checking bench for the fault flags and region checker
// Assumes: word accesses only, all byte lanes enabled
// Notes: bank 0 is secure, bank 1 non-secure
`timescale 1ns/10ps
module sfp_top_bench import sfp_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic ns = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, aaddr, aa, q;
  logic wreq, av, sexc, cv, cf, co, mme;
  logic [12:0] ev;
  logic [4:0] kd;
  logic [6:0] flags;
  logic [7:0] cattr;
  int n_errors = 0;
  int checks_done = 0;
  logic [12:0] ev_tab [12] = '{13'h1000, 13'h1800, 13'h1400, 13'h0200, 13'h0180, 13'h01e0,
    13'h01c0, 13'h0100, 13'h0010, 13'h0008, 13'h000c, 13'h000e};
  logic [6:0] fl_tab [12] = '{7'h48, 7'h60, 7'h40, 7'h10, 7'h04, 7'h04,
    7'h00, 7'h00, 7'h02, 7'h01, 7'h01, 7'h00};

  always #50 i_clk = ~i_clk;

  sfp_top #(.MPU_PRESENT(1'b1)) uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .i_avs_nonsecure(ns), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_attr_viol(ev[12]), .i_attr_addr(aaddr), .i_attr_lazy(ev[11]),
    .i_attr_vector(ev[10]), .i_bad_transition(ev[9]), .i_exc_ret(ev[8]),
    .i_exc_ret_nonsecure(ev[7]), .i_exc_ret_stacking(ev[6]), .i_exc_ret_secure(ev[5]),
    .i_unstack_bad_sig(ev[4]), .i_ns_entry(ev[3]), .i_entry_is_gateway(ev[2]),
    .i_entry_callable(ev[1]), .i_other_fault(ev[0]), .i_acc_valid(av),
    .i_acc_addr(aa), .i_acc_write(kd[4]), .i_acc_fetch(kd[3]), .i_acc_priv(kd[2]),
    .i_acc_nonsecure(kd[1]), .i_acc_neg_prio(kd[0]), .o_sf_flags(flags),
    .o_sec_fault_exc(sexc), .o_chk_valid(cv), .o_chk_fault(cf), .o_chk_overlap(co),
    .o_chk_attr(cattr), .o_mem_mgmt_exc(mme)
  );

  sfp_core_model core (
    .i_clk(i_clk), .o_ev(ev), .o_attr_addr(aaddr), .o_acc_valid(av),
    .o_acc_addr(aa), .o_acc_kind(kd)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic s, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    rd <= ~w;
    wr <= w;
    ns <= s;
    addr <= a;
    wd <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    r = rdata;
    if (wreq !== 1'b0) n_errors++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic acc(input logic [31:0] a, input logic [4:0] k, input logic e,
                     input logic o, input logic [7:0] at);
    core.access(a, k);
    @(negedge i_clk);
    chk("check", {28'h0, cv, cf, co, mme}, {28'h0, 1'b1, e, o, e});
    // attribute checked unless regions overlap, a miss reads as 00
    if (!o) chk("attr", {24'h0, cattr}, {24'h0, at});
  endtask : acc

  task automatic t_regs();
    bus(1'b0, 1'b0, ADDR_INFO, 32'h0, q);
    chk("info", q, {16'h0, INFO_COUNT_PRESENT, 7'h00, INFO_UNIFIED});
    bus(1'b1, 1'b0, ADDR_INFO, 32'hffffffff, q);
    bus(1'b0, 1'b0, ADDR_INFO, 32'h0, q);
    chk("info ro", q, {16'h0, INFO_COUNT_PRESENT, 7'h00, INFO_UNIFIED});
    bus(1'b0, 1'b0, ADDR_CTRL, 32'h0, q);
    chk("ctrl reset", q, 32'h0);
    bus(1'b1, 1'b0, ADDR_CTRL, 32'h7, q);
    bus(1'b0, 1'b1, ADDR_CTRL, 32'h0, q);
    chk("ctrl ns bank", q, 32'h0);
    bus(1'b0, 1'b0, ADDR_CTRL, 32'h0, q);
    chk("ctrl s bank", q, 32'h7);
    bus(1'b1, 1'b0, ADDR_CTRL, 32'h0, q);
    bus(1'b0, 1'b0, 32'he000edbc, 32'h0, q);
    chk("unmapped", q, 32'h0);
  endtask : t_regs

  task automatic t_events();
    for (int i = 0; i < 12; i++) begin
      core.pulse(ev_tab[i], 32'h10000040 ^ 32'(i));
      @(negedge i_clk);
      chk("flags", {25'h0, flags}, {25'h0, fl_tab[i]});
      chk("exc", {31'h0, sexc}, {31'h0, |fl_tab[i][5:0]});
      bus(1'b0, 1'b0, ADDR_SF_STATUS, 32'h0, q);
      chk("status", q, {25'h0, fl_tab[i]});
      if (fl_tab[i][6]) begin
        bus(1'b0, 1'b0, ADDR_SF_ADDRESS, 32'h0, q);
        chk("fault addr", q, 32'h10000040 ^ 32'(i));
      end
      bus(1'b1, 1'b0, ADDR_SF_STATUS, 32'h7f, q);
      bus(1'b0, 1'b0, ADDR_SF_STATUS, 32'h0, q);
      chk("cleared", q, 32'h0);
    end
  endtask : t_events

  task automatic t_views();
    core.pulse(13'h1000, 32'hcafe0010);
    core.pulse(13'h0001, 32'h0);
    @(negedge i_clk);
    chk("other fault", {25'h0, flags}, 32'h08);
    bus(1'b0, 1'b1, ADDR_SF_STATUS, 32'h0, q);
    chk("ns status", q, 32'h0);
    bus(1'b1, 1'b1, ADDR_SF_STATUS, 32'h7f, q);
    bus(1'b1, 1'b1, ADDR_SF_ADDRESS, 32'h0, q);
    bus(1'b0, 1'b1, ADDR_SF_ADDRESS, 32'h0, q);
    chk("ns address", q, 32'h0);
    bus(1'b0, 1'b0, ADDR_SF_STATUS, 32'h0, q);
    chk("status kept", q, 32'h08);
    bus(1'b0, 1'b0, ADDR_SF_ADDRESS, 32'h0, q);
    chk("address kept", q, 32'hcafe0010);
    bus(1'b1, 1'b0, ADDR_SF_STATUS, 32'h7f, q);
  endtask : t_views

  task automatic t_regions();
    acc(32'h30000000, 5'b00000, 1'b0, 1'b0, 8'h00);
    bus(1'b1, 1'b0, ADDR_ATTR_LO, 32'h44332211, q);
    bus(1'b1, 1'b0, ADDR_RSEL, 32'h0, q);
    bus(1'b1, 1'b0, ADDR_RBASE, 32'h20000002, q);
    bus(1'b1, 1'b0, ADDR_RLIM, 32'h20000fe5, q);
    bus(1'b1, 1'b0, ADDR_RSEL, 32'h4, q);
    bus(1'b1, 1'b0, ADDR_RBASE_A1, 32'h20000802, q);
    bus(1'b1, 1'b0, ADDR_RLIM_A1, 32'h20001fe1, q);
    bus(1'b0, 1'b0, ADDR_RSEL, 32'h0, q);
    chk("alias select", q, 32'h5);
    bus(1'b0, 1'b0, ADDR_RBASE, 32'h0, q);
    chk("alias base", q, 32'h20000802);
    bus(1'b1, 1'b0, ADDR_RBASE_A3, 32'h60000000, q);
    bus(1'b0, 1'b0, ADDR_RBASE, 32'h0, q);
    chk("alias3 base", q, 32'h60000000);
    bus(1'b0, 1'b0, ADDR_RLIM_A2, 32'h0, q);
    chk("alias2 limit", q, 32'h0);
    bus(1'b0, 1'b0, ADDR_RSEL, 32'h0, q);
    chk("alias2 select", q, 32'h6);
    bus(1'b1, 1'b0, ADDR_ATTR_HI, 32'h88776655, q);
    bus(1'b0, 1'b0, ADDR_ATTR_HI, 32'h0, q);
    chk("attr high", q, 32'h88776655);
    bus(1'b1, 1'b0, ADDR_CTRL, 32'h1, q);
    acc(32'h20000100, 5'b00100, 1'b0, 1'b0, 8'h33);
    acc(32'h20000100, 5'b01000, 1'b0, 1'b0, 8'h33);
    acc(32'h20001000, 5'b10000, 1'b0, 1'b0, 8'h11);
    acc(32'h20000900, 5'b00100, 1'b1, 1'b1, 8'h00);
    acc(32'h30000000, 5'b00100, 1'b1, 1'b0, 8'h00);
    acc(32'h30000000, 5'b00101, 1'b0, 1'b0, 8'h00);
    acc(32'h30000000, 5'b00110, 1'b0, 1'b0, 8'h00);
    bus(1'b1, 1'b0, ADDR_CTRL, 32'h7, q);
    acc(32'h30000000, 5'b00100, 1'b0, 1'b0, 8'h00);
    acc(32'h30000000, 5'b00000, 1'b1, 1'b0, 8'h00);
    acc(32'h30000000, 5'b00001, 1'b1, 1'b0, 8'h00);
  endtask : t_regions

  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // the whole run needs a few hundred cycles
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_regs();
    t_events();
    t_views();
    t_regions();
    end_of_test();
  end
endmodule : sfp_top_bench
